// ---- inc/peir_pkg.sv ----
// Constants and types of the PSE event flag and interrupt mask registers
package peir_pkg;

    // ========================================================
    // Geometry
    localparam int         NUM_CH       = 4;
    localparam int         NUM_PAIR     = 2;
    localparam int         RES_W        = 4;

    // ========================================================
    // Command codes
    localparam logic [7:0] CMD_MASK     = 8'h01;
    localparam logic [7:0] CMD_PWR_EV   = 8'h02;
    localparam logic [7:0] CMD_PWR_EV_C = 8'h03;
    localparam logic [7:0] CMD_DISC_EV  = 8'h04;
    localparam logic [7:0] CMD_DISC_EV_C = 8'h05;
    localparam logic [7:0] CMD_FLT_EV   = 8'h06;
    localparam logic [7:0] CMD_FLT_EV_C = 8'h07;

    // ========================================================
    // Reset values
    localparam logic [7:0] MASK_RESET   = 8'h80;
    localparam logic [7:0] EV_RESET     = 8'h00;
    localparam logic [7:0] RDATA_IDLE   = 8'h00;
    localparam logic [3:0] RES_RESET    = 4'h0;

    // ========================================================
    // Summary and mask bit positions
    localparam int         BIT_SUPPLY   = 7;
    localparam int         BIT_START    = 6;
    localparam int         BIT_OVLD     = 5;
    localparam int         BIT_CLASS    = 4;
    localparam int         BIT_DETECT   = 3;
    localparam int         BIT_DISC     = 2;
    localparam int         BIT_PGOOD    = 1;
    localparam int         BIT_PEN      = 0;

    // Event register halves: upper nibble and lower nibble
    localparam int         FLD_HI       = 4;
    localparam int         FLD_LO       = 0;

    // ========================================================
    // Discovery mode of a port
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_MANUAL = 2'b01,
        MODE_SEMI   = 2'b10,
        MODE_AUTO   = 2'b11
    } peir_mode_t;

endpackage

// ---- inc/peir_ev_if.sv ----
// Connection between the top and one sticky event register
`timescale 1ns/1ps
`default_nettype none
interface peir_ev_if;
    logic [7:0] set;
    logic       clr_all;
    logic [7:0] clr_ch;
    logic [7:0] flags;
    modport owner (input set, input clr_all, input clr_ch, output flags);
    modport user  (output set, output clr_all, output clr_ch, input flags);
endinterface
`default_nettype wire

// ---- rtl/peir_event_reg.sv ----
// Eight sticky event flags with clear-on-read and per-channel clear
`timescale 1ns/1ps
`default_nettype none
module peir_event_reg
    import peir_pkg::*;
(
    input  wire logic  i_clk,   // System clock
    input  wire logic  i_rst_n, // Synchronised reset, active low
    peir_ev_if.owner   ev       // Set, clear and flag lines
);

    // ========================================================
    // Flags: a set in the clearing cycle wins
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ev.flags <= EV_RESET;
        end else if (ev.clr_all) begin
            ev.flags <= ev.set;
        end else begin
            ev.flags <= ev.set | (ev.flags & ~ev.clr_ch);
        end
    end

endmodule // peir_event_reg
`default_nettype wire

// ---- rtl/peir_pair_merge.sv ----
// Joins the events of the two channels of a four-pair port
`timescale 1ns/1ps
`default_nettype none
module peir_pair_merge (
    input  wire logic       i_clk,   // System clock
    input  wire logic       i_rst_n, // Synchronised reset, active low
    input  wire logic       i_merge, // Report both channels together
    input  wire logic [1:0] i_ev,    // Raw per-channel event pulses
    input  wire logic [1:0] i_clr,   // Channel turned off
    output logic      [1:0] o_ev     // Event pulses to the flags
);

    logic [1:0] pend;
    logic [1:0] seen;

    assign seen = pend | i_ev;

    // ========================================================
    // Release both flags once both channels have reported
    always_comb begin
        if (!i_merge) begin
            o_ev = i_ev;
        end else if (&seen) begin
            o_ev = 2'b11;
        end else begin
            o_ev = 2'b00;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend <= 2'b00;
        end else if (!i_merge || (&seen)) begin
            pend <= 2'b00;
        end else begin
            pend <= (pend & ~i_clr) | i_ev;
        end
    end

endmodule // peir_pair_merge
`default_nettype wire

// ---- rtl/peir_top.sv ----
// Event flags, interrupt mask and interrupt pin of a four-channel PSE
//
// Function
// - Mask bit 7 resets to 1 and gates supply faults onto the pin.
// - Mask bits 6..0 reset to 0 and gate their event classes.
// - Power events read alike at both codes; the clear code clears all.
// - A clear-on-read of the source register releases the pin.
// - Every set event bit feeds its summary bit.
// - Power register: upper nibble power-good change, lower power-enable.
// - Four-pair ports update power-enable change flags per channel.
// - Single-signature four-pair: power-good flags set after both change.
// - Dual-signature four-pair: power flags set per channel.
// - Discovery events clear on read and per channel at turn-off.
// - Class flags set per cycle, or only on class change if chosen.
// - Detect flags set per cycle, or only on result change if chosen.
// - Four-pair without power-on command: detect flags set together, except dual-signature auto.
// - Single-signature class flag only for the classified channel.
// - Dual-signature semi-auto class flags together; manual per channel.
// - Dual-signature with power-on command or auto: flags independent.
// - Fault events: disconnect high, power-cut low; clear on read/off.
// - Pin asserts only for a set summary bit, its mask and global enable.
// - Summary bits follow events whatever the mask.
// - Disconnect flags mark load removal; power-cut flags overload timeout.
`timescale 1ns/1ps
`default_nettype none
module peir_top
    import peir_pkg::*;
(
    input  wire logic        I_CLK_SYS,     // 20 MHz system clock
    input  wire logic        I_RST_N,       // Async reset, active low
    input  wire logic        I_REG_RD,      // Register read strobe
    input  wire logic        I_REG_WR,      // Register write strobe
    input  wire logic [7:0]  I_REG_ADDR,    // Command code
    input  wire logic [7:0]  I_REG_WDATA,   // Write data
    output logic      [7:0]  O_REG_RDATA,   // Read data
    output logic             O_REG_RVALID,  // Read data valid pulse
    input  wire logic [3:0]  I_PEN_CHG,     // Power-enable change pulse
    input  wire logic [3:0]  I_PGOOD_CHG,   // Power-good change pulse
    input  wire logic [3:0]  I_DET_DONE,    // Detection cycle done pulse
    input  wire logic [15:0] I_DET_RESULT,  // Detection result per ch
    input  wire logic [3:0]  I_CLS_DONE,    // Class cycle done pulse
    input  wire logic [15:0] I_CLS_RESULT,  // Class result per ch
    input  wire logic [3:0]  I_LOAD_DISC,   // Load disconnected pulse
    input  wire logic [3:0]  I_OVLD_TO,     // Overload timeout pulse
    input  wire logic [3:0]  I_CH_OFF,      // Channel turned off pulse
    input  wire logic        I_START_FAULT, // Start fault pending level
    input  wire logic        I_ILIM_FAULT,  // Current-limit fault level
    input  wire logic        I_SUPPLY_FAULT, // Supply/memory fault level
    input  wire logic        I_GLOBAL_IRQ_ENABLE, // Global enable
    input  wire logic        I_CLASS_CHANGE_ONLY,  // Class change only
    input  wire logic        I_DETECT_CHANGE_ONLY, // Detect change only
    input  wire logic [1:0]  I_FOUR_PAIR,   // Port wired four-pair
    input  wire logic [1:0]  I_DUAL_SIG,    // Dual-signature load
    input  wire logic [1:0]  I_CHANNEL_POWER_ON_CMD, // Power-on pending
    input  wire logic [3:0]  I_PORT_MODE,   // Mode, two bits per port
    output logic      [7:0]  O_IRQ_SUMMARY, // Summary interrupt bits
    output logic             O_INT_N        // Interrupt pin, active low
);

    // ========================================================
    // Decoding helpers
    function automatic logic cmd_pair(input logic [7:0] a,
                                      input logic [7:0] base);
        cmd_pair = ({a[7:1], 1'b0} == base);
    endfunction

    function automatic logic cmd_clear(input logic       rd,
                                       input logic [7:0] a,
                                       input logic [7:0] base);
        cmd_clear = rd && cmd_pair(a, base) && a[0];
    endfunction

    // ========================================================
    // Reset release
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ========================================================
    // Interrupt mask register
    logic [7:0] irq_mask;

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= MASK_RESET;
        end else if (I_REG_WR && (I_REG_ADDR == CMD_MASK)) begin
            irq_mask <= I_REG_WDATA;
        end
    end

    logic supply_fault_irq_enable;
    logic start_fault_irq_enable;
    logic overcurrent_irq_enable;
    logic class_cycle_irq_enable;
    logic detect_cycle_irq_enable;
    logic disconnect_irq_enable;
    logic power_good_irq_enable;
    logic power_enable_irq_enable;

    assign supply_fault_irq_enable = irq_mask[BIT_SUPPLY];
    assign start_fault_irq_enable  = irq_mask[BIT_START];
    assign overcurrent_irq_enable  = irq_mask[BIT_OVLD];
    assign class_cycle_irq_enable  = irq_mask[BIT_CLASS];
    assign detect_cycle_irq_enable = irq_mask[BIT_DETECT];
    assign disconnect_irq_enable   = irq_mask[BIT_DISC];
    assign power_good_irq_enable   = irq_mask[BIT_PGOOD];
    assign power_enable_irq_enable = irq_mask[BIT_PEN];

    // ========================================================
    // Result change detection per channel
    logic [3:0] det_changed;
    logic [3:0] cls_changed;
    logic [3:0] prev_det [NUM_CH];
    logic [3:0] prev_cls [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_res
        always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
            if (!rst_n) begin
                prev_det[c] <= RES_RESET;
            end else if (I_DET_DONE[c]) begin
                prev_det[c] <= I_DET_RESULT[c*RES_W +: RES_W];
            end
        end

        always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
            if (!rst_n) begin
                prev_cls[c] <= RES_RESET;
            end else if (I_CLS_DONE[c]) begin
                prev_cls[c] <= I_CLS_RESULT[c*RES_W +: RES_W];
            end
        end

        assign det_changed[c] = I_DET_DONE[c] &&
            (I_DET_RESULT[c*RES_W +: RES_W] != prev_det[c]);
        assign cls_changed[c] = I_CLS_DONE[c] &&
            (I_CLS_RESULT[c*RES_W +: RES_W] != prev_cls[c]);
    end

    // Cycle or change, as chosen
    logic [3:0] det_event;
    logic [3:0] cls_event;

    assign det_event = I_DETECT_CHANGE_ONLY ? det_changed
                                            : I_DET_DONE;
    assign cls_event = I_CLASS_CHANGE_ONLY ? cls_changed
                                           : I_CLS_DONE;

    // ========================================================
    // Four-pair joining, one set of merges per port
    logic [3:0] pgood_set;
    logic [3:0] det_set;
    logic [3:0] cls_set;

    for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
        peir_mode_t md;
        logic       four_pair;
        logic       dual;
        logic       channel_power_on_cmd;
        logic       pg_merge;
        logic       det_merge;
        logic       cls_merge;

        assign md        = peir_mode_t'(I_PORT_MODE[p*2 +: 2]);
        assign four_pair = I_FOUR_PAIR[p];
        assign dual      = I_DUAL_SIG[p];
        assign channel_power_on_cmd      = I_CHANNEL_POWER_ON_CMD[p];

        assign pg_merge  = four_pair && !dual;
        assign det_merge = four_pair && !channel_power_on_cmd &&
                           !(dual && (md == MODE_AUTO));
        assign cls_merge = four_pair && dual && !channel_power_on_cmd &&
                           (md == MODE_SEMI);

        peir_pair_merge u_pg (
            .i_clk   (I_CLK_SYS),
            .i_rst_n (rst_n),
            .i_merge (pg_merge),
            .i_ev    (I_PGOOD_CHG[p*2 +: 2]),
            .i_clr   (I_CH_OFF[p*2 +: 2]),
            .o_ev    (pgood_set[p*2 +: 2])
        );

        peir_pair_merge u_det (
            .i_clk   (I_CLK_SYS),
            .i_rst_n (rst_n),
            .i_merge (det_merge),
            .i_ev    (det_event[p*2 +: 2]),
            .i_clr   (I_CH_OFF[p*2 +: 2]),
            .o_ev    (det_set[p*2 +: 2])
        );

        peir_pair_merge u_cls (
            .i_clk   (I_CLK_SYS),
            .i_rst_n (rst_n),
            .i_merge (cls_merge),
            .i_ev    (cls_event[p*2 +: 2]),
            .i_clr   (I_CH_OFF[p*2 +: 2]),
            .o_ev    (cls_set[p*2 +: 2])
        );
    end

    // ========================================================
    // Event registers
    peir_ev_if pwr_ev ();
    peir_ev_if disc_ev ();
    peir_ev_if flt_ev ();

    // Power-enable flags are never joined across the port
    assign pwr_ev.set     = {pgood_set, I_PEN_CHG};
    assign pwr_ev.clr_all = cmd_clear(I_REG_RD, I_REG_ADDR,
                                      CMD_PWR_EV);
    assign pwr_ev.clr_ch  = 8'h00;

    assign disc_ev.set     = {cls_set, det_set};
    assign disc_ev.clr_all = cmd_clear(I_REG_RD, I_REG_ADDR,
                                       CMD_DISC_EV);
    assign disc_ev.clr_ch  = {I_CH_OFF, I_CH_OFF};

    assign flt_ev.set     = {I_LOAD_DISC, I_OVLD_TO};
    assign flt_ev.clr_all = cmd_clear(I_REG_RD, I_REG_ADDR,
                                      CMD_FLT_EV);
    assign flt_ev.clr_ch  = {I_CH_OFF, I_CH_OFF};

    peir_event_reg u_pwr_ev (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (rst_n),
        .ev      (pwr_ev)
    );

    peir_event_reg u_disc_ev (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (rst_n),
        .ev      (disc_ev)
    );

    peir_event_reg u_flt_ev (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (rst_n),
        .ev      (flt_ev)
    );

    // ========================================================
    // Summary bits and interrupt pin
    logic [7:0] next_summary;
    logic       next_int_n;

    always_comb begin
        next_summary             = 8'h00;
        next_summary[BIT_SUPPLY] = I_SUPPLY_FAULT;
        next_summary[BIT_START]  = I_START_FAULT;
        next_summary[BIT_OVLD]   = I_ILIM_FAULT ||
                                   (|flt_ev.flags[FLD_LO +: 4]);
        next_summary[BIT_CLASS]  = |disc_ev.flags[FLD_HI +: 4];
        next_summary[BIT_DETECT] = |disc_ev.flags[FLD_LO +: 4];
        next_summary[BIT_DISC]   = |flt_ev.flags[FLD_HI +: 4];
        next_summary[BIT_PGOOD]  = |pwr_ev.flags[FLD_HI +: 4];
        next_summary[BIT_PEN]    = |pwr_ev.flags[FLD_LO +: 4];
    end

    // Mask gates only the pin, never the summary
    assign next_int_n = !(I_GLOBAL_IRQ_ENABLE &&
                          (|(next_summary & irq_mask)));

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            O_IRQ_SUMMARY <= 8'h00;
        end else begin
            O_IRQ_SUMMARY <= next_summary;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            O_INT_N <= 1'b1;
        end else begin
            O_INT_N <= next_int_n;
        end
    end

    // ========================================================
    // Read port: both codes of a pair return the same byte
    logic [7:0] next_rdata;

    always_comb begin
        if (I_REG_ADDR == CMD_MASK) begin
            next_rdata = irq_mask;
        end else if (cmd_pair(I_REG_ADDR, CMD_PWR_EV)) begin
            next_rdata = pwr_ev.flags;
        end else if (cmd_pair(I_REG_ADDR, CMD_DISC_EV)) begin
            next_rdata = disc_ev.flags;
        end else if (cmd_pair(I_REG_ADDR, CMD_FLT_EV)) begin
            next_rdata = flt_ev.flags;
        end else begin
            next_rdata = RDATA_IDLE;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            O_REG_RDATA  <= RDATA_IDLE;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= next_rdata;
            end
        end
    end

endmodule // peir_top
`default_nettype wire

// ---- verif/peir_top_asserts.sv ----
// Port checks of the event flag and interrupt block
`timescale 1ns/1ps
`default_nettype none
module peir_top_asserts
    import peir_pkg::*;
(
    input wire logic       I_CLK_SYS,           // Clock
    input wire logic       I_RST_N,             // Reset, active low
    input wire logic       I_REG_RD,            // Read strobe
    input wire logic [7:0] I_REG_ADDR,          // Code
    input wire logic [7:0] O_REG_RDATA,         // Read data
    input wire logic       O_REG_RVALID,        // Read valid
    input wire logic [3:0] I_PEN_CHG,           // Enable change
    input wire logic [3:0] I_LOAD_DISC,         // Disconnect
    input wire logic [3:0] I_OVLD_TO,           // Power cut
    input wire logic       I_SUPPLY_FAULT,      // Supply fault
    input wire logic       I_GLOBAL_IRQ_ENABLE, // Global enable
    input wire logic [7:0] O_IRQ_SUMMARY,       // Summary
    input wire logic       O_INT_N              // Pin
);
    // ========================================================
    // Cycles since reset release, saturating
    logic [1:0] up_cnt;
    logic       ready;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    assign ready = (up_cnt == 2'h3);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    // ========================================================
    // Assertions
    sequence s_two_later(logic b);
        ##2 b;
    endsequence
    a_rvalid_follows_rd: assert property (
        ready && I_REG_RD |=> O_REG_RVALID)
        else $error("read not answered");
    a_rvalid_needs_rd: assert property (
        O_REG_RVALID |-> $past(I_REG_RD))
        else $error("valid without read");
    a_rdata_holds: assert property (
        !O_REG_RVALID |-> $stable(O_REG_RDATA))
        else $error("read data moved");
    a_unmapped_zero: assert property (
        ready && I_REG_RD && I_REG_ADDR > CMD_FLT_EV_C
        |=> O_REG_RDATA == RDATA_IDLE)
        else $error("unmapped read not zero");
    a_pen_to_summary: assert property (
        ready && |I_PEN_CHG |-> s_two_later(O_IRQ_SUMMARY[BIT_PEN]))
        else $error("enable change missing");
    a_disc_to_summary: assert property (
        ready && |I_LOAD_DISC |-> s_two_later(O_IRQ_SUMMARY[BIT_DISC]))
        else $error("disconnect missing");
    a_cut_to_summary: assert property (
        ready && |I_OVLD_TO |-> s_two_later(O_IRQ_SUMMARY[BIT_OVLD]))
        else $error("power cut missing");
    a_supply_summary: assert property (
        ready && I_SUPPLY_FAULT |=> O_IRQ_SUMMARY[BIT_SUPPLY])
        else $error("supply fault missing");
    a_pin_needs_enable: assert property (
        !O_INT_N |-> $past(I_GLOBAL_IRQ_ENABLE))
        else $error("pin low while disabled");
    a_pin_needs_summary: assert property (
        !O_INT_N |-> O_IRQ_SUMMARY != 8'h00)
        else $error("pin low without summary");
endmodule // peir_top_asserts
`default_nettype wire

// ---- verif/peir_host_model.sv ----
// Host processor model driving the command port
`timescale 1ns/1ps
`default_nettype none
module peir_host_model (
    input  wire logic       i_clk,  // Clock
    output logic            o_rd,   // Read strobe
    output logic            o_wr,   // Write strobe
    output logic      [7:0] o_addr, // Code
    output logic      [7:0] o_wdata // Write data
);
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'h5a;
        o_wdata = 8'ha5;
    end
    // One access, taken at the rising edge between two falling edges
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge i_clk);
        o_rd = ~w;
        o_wr = w;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_wr = 1'b0;
        // Idle lines carry no stale value
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic reg_read(input logic [7:0] a);
        access(1'b0, a, 8'h00);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask
endmodule // peir_host_model
`default_nettype wire

// ---- verif/peir_top_tb.sv ----
// Self-checking bench of the event flag and interrupt block
`timescale 1ns/1ps
`default_nettype none
bind peir_top peir_top_asserts peir_top_asserts_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_REG_RD(I_REG_RD),
    .I_REG_ADDR(I_REG_ADDR), .O_REG_RDATA(O_REG_RDATA),
    .O_REG_RVALID(O_REG_RVALID), .I_PEN_CHG(I_PEN_CHG),
    .I_LOAD_DISC(I_LOAD_DISC), .I_OVLD_TO(I_OVLD_TO),
    .I_SUPPLY_FAULT(I_SUPPLY_FAULT),
    .I_GLOBAL_IRQ_ENABLE(I_GLOBAL_IRQ_ENABLE),
    .O_IRQ_SUMMARY(O_IRQ_SUMMARY), .O_INT_N(O_INT_N));
module peir_top_tb
    import peir_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [3:0]  ev [7];
    logic [15:0] det_res;
    logic [15:0] cls_res;
    logic [2:0]  lvl;
    logic        gen;
    logic        cls_only;
    logic        det_only;
    logic [1:0]  four_pair;
    logic [1:0]  dual;
    logic [1:0]  channel_power_on_cmd;
    logic [3:0]  mode;
    logic [7:0]  summary;
    logic        int_n;
    logic [7:0]  exp_q [$];
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    peir_top peir_top_inst (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_RD(rd), .I_REG_WR(wr),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .I_PEN_CHG(ev[0]), .I_PGOOD_CHG(ev[1]),
        .I_DET_DONE(ev[2]), .I_DET_RESULT(det_res), .I_CLS_DONE(ev[3]),
        .I_CLS_RESULT(cls_res), .I_LOAD_DISC(ev[4]), .I_OVLD_TO(ev[5]),
        .I_CH_OFF(ev[6]), .I_START_FAULT(lvl[1]), .I_ILIM_FAULT(lvl[2]),
        .I_SUPPLY_FAULT(lvl[0]), .I_GLOBAL_IRQ_ENABLE(gen),
        .I_CLASS_CHANGE_ONLY(cls_only), .I_DETECT_CHANGE_ONLY(det_only),
        .I_FOUR_PAIR(four_pair), .I_DUAL_SIG(dual),
        .I_CHANNEL_POWER_ON_CMD(channel_power_on_cmd), .I_PORT_MODE(mode),
        .O_IRQ_SUMMARY(summary), .O_INT_N(int_n));
    peir_host_model peir_host_model_inst (
        .i_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr),
        .o_wdata(wdata));
    // ========================================================
    // Shared tasks
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        peir_host_model_inst.reg_read(a);
    endtask
    task automatic wr_mask(input logic [7:0] d);
        peir_host_model_inst.reg_write(CMD_MASK, d);
    endtask
    task automatic fire(input int k, input logic [3:0] b);
        @(negedge clk);
        ev[k] = b;
        @(negedge clk);
        ev[k] = 4'h0;
    endtask
    task automatic pin_is(input logic e);
        repeat (2) @(negedge clk);
        chk({7'h00, int_n}, {7'h00, e});
    endtask
    task automatic dc(input logic [7:0] a, input logic [7:0] e);
        fire(2, 4'h1);
        fire(3, 4'h1);
        rd_exp(a, e);
    endtask
    // ========================================================
    // Clock, watchdog and read-data monitor
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() > 0) begin
                chk(rdata, exp_q.pop_front());
            end else begin
                n_errors++;
                $display("Error at %0t: got %h expected %h", $time,
                         rdata, 8'h00);
            end
        end
    end
    // ========================================================
    // Main sequence
    initial begin
        logic [7:0] r;
        rst_n = 1'b0;
        ev = '{default: 4'h0};
        det_res = 16'h0000;
        cls_res = 16'h0000;
        lvl = 3'h0;
        gen = 1'b1;
        cls_only = 1'b0;
        det_only = 1'b0;
        four_pair = 2'b11;
        dual = 2'b10;
        channel_power_on_cmd = 2'b00;
        mode = 4'b1001;
        void'($urandom(32'hce8e1d4d));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd_exp(CMD_MASK, MASK_RESET);
        for (int a = 2; a < 8; a++) rd_exp(8'(a), EV_RESET);
        peir_host_model_inst.reg_write(CMD_PWR_EV, 8'hff);
        rd_exp(CMD_PWR_EV, 8'h00);
        repeat (4) begin
            r = 8'($urandom);
            wr_mask(r);
            rd_exp(CMD_MASK, r);
            rd_exp(8'(8 + $urandom_range(247)), RDATA_IDLE);
        end
        wr_mask(8'h00);
        for (int i = 0; i < 3; i++) begin
            lvl[i] = 1'b1;
            pin_is(1'b1);
            chk(summary & (8'h80 >> i), 8'h80 >> i);
            wr_mask(8'h80 >> i);
            pin_is(1'b0);
            gen = 1'b0;
            pin_is(1'b1);
            gen = 1'b1;
            lvl[i] = 1'b0;
            wr_mask(8'h00);
        end
        fire(4, 4'b0001);
        fire(5, 4'b1000);
        pin_is(1'b1);
        chk(summary, 8'h24);
        rd_exp(CMD_FLT_EV, 8'h18);
        fire(6, 4'b1000);
        rd_exp(CMD_FLT_EV_C, 8'h10);
        rd_exp(CMD_FLT_EV, 8'h00);
        wr_mask(8'hff);
        fire(0, 4'b0101);
        pin_is(1'b0);
        rd_exp(CMD_PWR_EV, 8'h05);
        rd_exp(CMD_PWR_EV_C, 8'h05);
        pin_is(1'b1);
        rd_exp(CMD_PWR_EV, 8'h00);
        fire(1, 4'b0001);
        rd_exp(CMD_PWR_EV, 8'h00);
        fire(1, 4'b0110);
        rd_exp(CMD_PWR_EV_C, 8'h70);
        fire(2, 4'b0001);
        rd_exp(CMD_DISC_EV, 8'h00);
        fire(2, 4'b0010);
        rd_exp(CMD_DISC_EV_C, 8'h03);
        fire(3, 4'b0001);
        rd_exp(CMD_DISC_EV_C, 8'h10);
        fire(3, 4'b0100);
        rd_exp(CMD_DISC_EV, 8'h00);
        fire(3, 4'b1000);
        rd_exp(CMD_DISC_EV_C, 8'hc0);
        mode = 4'b0101;
        fire(3, 4'b0100);
        rd_exp(CMD_DISC_EV_C, 8'h40);
        channel_power_on_cmd = 2'b10;
        fire(2, 4'b0100);
        rd_exp(CMD_DISC_EV_C, 8'h04);
        channel_power_on_cmd = 2'b00;
        mode = 4'b1101;
        fire(2, 4'b0100);
        rd_exp(CMD_DISC_EV_C, 8'h04);
        four_pair = 2'b00;
        det_only = 1'b1;
        cls_only = 1'b1;
        dc(CMD_DISC_EV_C, 8'h00);
        det_res = 16'h0005;
        cls_res = 16'h0003;
        dc(CMD_DISC_EV_C, 8'h11);
        dc(CMD_DISC_EV_C, 8'h00);
        det_only = 1'b0;
        cls_only = 1'b0;
        dc(CMD_DISC_EV, 8'h11);
        fire(6, 4'b0001);
        rd_exp(CMD_DISC_EV, 8'h00);
        repeat (4) @(negedge clk);
        complete_run();
    end
endmodule // peir_top_tb
`default_nettype wire
